// File: tb/test_timer2_reload_capture.sv
// self-checking bench for the reload/capture timer
`timescale 1ns/10ps
`default_nettype none
`include "tmr2_defs.vh"
module test_timer2_reload_capture;
	logic        aclk = 0, aresetn = 0, clk_en = 1, pin_req = 0, ext_trigger_dir_pin;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, q;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	integer      seed = 32'h17C77C7E, n_mismatch = 0, checks_done = 0;
	logic [15:0] rel, cnt, cn [8] = '{16'hFFFE, 0, 0, 0, 0, 16'hFFFE, 16'hFFFC, 0};
	logic [9:0]  ct [8] = '{10'h321, 10'h321, 10'h329, 10'h339, 10'h325, 10'h325, 10'h333, 10'h023};
	logic [7:0]  pv = 8'hA4, tg = 8'hCE;
	always #4 aclk = ~aclk;
	tmr2_timer #(.PRESCALE(`TMR2_PRESCALE)) dut (.aclk, .aresetn, .clk_en, .ext_trigger_dir_pin, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq);
	tmr2_pin_model u_pin (.aclk, .level_req(pin_req), .pin(ext_trigger_dir_pin));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		chk("bresp", s_axi_bresp, 0);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		chk("rresp", s_axi_rresp, 0);
	endtask
	// ten prescaled ticks, pin event between the fifth and sixth
	function automatic logic [33:0] sim(input logic [9:0] t, input logic [15:0] c, r, input logic p, e);
		logic [1:0] st;
		st = 2'h0;
		for (int k = 1; k <= 10; k++) begin
			if (t[2] && !p)
				c = (c == r) ? 16'hFFFF : c - 16'h0001;
			else if (c == 16'hFFFF) begin
				c = t[1] ? 16'h0000 : r;
				st[0] = st[0] | !t[2];
			end else
				c = c + 16'h0001;
			if (k == 5 && e && t[1]) begin
				r = c;
				st[1] = 1'b1;
			end else if (k == 5 && e && t[3]) begin
				c = r;
				st[0] = 1'b1;
			end
		end
		return {st, r, c};
	endfunction
	task automatic run(input logic [9:0] t, input logic [15:0] c, r, input logic p, e);
		logic [33:0] x;
		x = sim(t, c, r, p, e);
		pin_req <= p;
		repeat (3) @(posedge aclk);
		wr(`TMR2_OFS_COUNT, c);
		wr(`TMR2_OFS_RELOAD, r);
		wr(`TMR2_OFS_STATUS, 3);
		wr(`TMR2_OFS_CTRL, t);
		repeat (30) @(posedge aclk);
		// frozen edges shift every later tick but must not lose one
		clk_en <= 1'b0;
		repeat (7) @(posedge aclk);
		clk_en <= 1'b1;
		repeat (30) @(posedge aclk);
		if (e) pin_req <= ~p;
		repeat (59) @(posedge aclk);
		wr(`TMR2_OFS_CTRL, t & 10'h3FE);
		rd(`TMR2_OFS_COUNT, q);
		chk("count", q, x[15:0]);
		rd(`TMR2_OFS_RELOAD, q);
		chk("reload", q, x[31:16]);
		rd(`TMR2_OFS_STATUS, q);
		chk("status", q, x[33:32]);
		chk("irq", irq, |(x[33:32] & t[9:8]));
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`TMR2_OFS_CTRL, q);
		chk("ctrl", q, `TMR2_CTRL_RST);
		for (int i = 0; i < 8; i++) begin
			rel = $random(seed);
			cnt = (i == 4) ? rel + 16'h0003 : (cn[i] == 0 ? $random(seed) : cn[i]);
			run(ct[i], cnt, rel, pv[i], tg[i]);
		end
		summarize;
	end
endmodule
`default_nettype wire

// File: tb/tmr2_pin_model.sv
// far-side circuit driving the trigger and direction pin
`timescale 1ns/10ps
`default_nettype none
module tmr2_pin_model (
	input  wire logic aclk,
	input  wire logic level_req,
	output var  logic pin
);
	initial pin = 1'b0;
	// level held between commands, so edges come only when asked
	always @(posedge aclk) pin <= level_req;
endmodule
`default_nettype wire

// File: tb/tmr2_timer_chk.sv
// bus and interrupt assertions for tmr2_timer
`timescale 1ns/10ps
`default_nettype none
module tmr2_timer_chk (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       clk_en,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
	chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while response pending");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en |=> s_axi_bvalid)
		else $error("no write response");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
		else $error("no read response");
	chk_irq_sticky: assert property (irq |=> irq || $rose(s_axi_bvalid))
		else $error("interrupt fell without a write");
	chk_irq_reset: assert property ($rose(aresetn) |-> !irq)
		else $error("interrupt high after reset");
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind tmr2_timer tmr2_timer_chk u_chk (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .irq);
`default_nettype wire

// File: verilog/tmr2_defs.vh
// register offsets, field positions, reset values and timing counts of the reload/capture timer
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMR2_OFS_CTRL      4'h0
`define TMR2_OFS_RELOAD    4'h4
`define TMR2_OFS_COUNT     4'h8
`define TMR2_OFS_STATUS    4'hC

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TMR2_CTRL_RUN      0
`define TMR2_CTRL_CAPMODE  1
`define TMR2_CTRL_UPDOWN   2
`define TMR2_CTRL_EXTEN    3
`define TMR2_CTRL_RISE     4
`define TMR2_CTRL_PREDIS   5
`define TMR2_CTRL_MASK_LO  8
`define TMR2_CTRL_W        10

// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define TMR2_ST_RELOAD     0
`define TMR2_ST_CAPTURE    1
`define TMR2_CTRL_RST      10'h020
`define TMR2_CNT_RST       16'h0000
`define TMR2_ONES          16'hFFFF
`define TMR2_ZERO          16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TMR2_PRESCALE      12
`define TMR2_PRE_W         4

`endif

// File: verilog/tmr2_timer.v
// 16-bit auto-reload / capture timer with AXI4-Lite register slave
// ----------------------------------------------------------------
// Notes on behaviour
// - one 16-bit counter, reload or capture mode
// - prescaler off: advance every twelve clocks
// - counts while run set, never self-stops
// - plain reload mode counts up from reload
// - reload on overflow, optionally external edge too
// - upward reload loads reload/capture register
// - plain reload mode: interrupt every reload
// - up/down mode: pin level sets direction
// - up/down mode raises no interrupt
// - counting up: reload only on overflow
// - down: from all ones, underflow at register
// - capture mode counts up from zero
// - chosen pin edge triggers capture
// - capture copies count into register
// - capture mode: interrupt on overflow or capture
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "tmr2_defs.vh"

module tmr2_timer #(
	parameter PRESCALE = `TMR2_PRESCALE
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        clk_en,
	input  wire        ext_trigger_dir_pin,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [`TMR2_CTRL_W-1:0] ctrl_q;
	reg  [15:0]             reload_capture_value_q;
	reg  [15:0]             timer_count_value_q;
	reg  [1:0]              status_q;
	reg  [`TMR2_PRE_W-1:0]  pre_q;
	reg                     pin_q;
	reg  [3:0]              awaddr_q;
	reg  [31:0]             wdata_q;
	reg  [3:0]              wstrb_q;
	reg                     aw_full_q;
	reg                     w_full_q;
	reg  [`TMR2_CTRL_W-1:0] ctrl_d;
	reg  [15:0]             reload_capture_value_d;
	reg  [15:0]             timer_count_value_d;
	reg  [1:0]              status_d;
	reg  [`TMR2_PRE_W-1:0]  pre_d;

	localparam [1:0] RESP_OKAY    = 2'h0;
	localparam [1:0] RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// counting modes
	// ----------------------------------------------------------------
	localparam [1:0] MODE_RELOAD  = 2'b00;
	localparam [1:0] MODE_UPDOWN  = 2'b01;
	localparam [1:0] MODE_CAPTURE = 2'b10;

	// capture mode overrides the up/down enable
	function [1:0] mode_of;
		input cap;
		input ud;
		begin
			if (cap) begin
				mode_of = MODE_CAPTURE;
			end else if (ud) begin
				mode_of = MODE_UPDOWN;
			end else begin
				mode_of = MODE_RELOAD;
			end
		end
	endfunction

	// edge of the chosen polarity between last and present pin sample
	function edge_seen;
		input rise;
		input now;
		input prev;
		begin
			if (rise) begin
				edge_seen = now && !prev;
			end else begin
				edge_seen = !now && prev;
			end
		end
	endfunction

	// offset decode shared by the write and the read channel
	function is_mapped;
		input [3:0] addr;
		begin
			case (addr)
			`TMR2_OFS_CTRL, `TMR2_OFS_RELOAD, `TMR2_OFS_COUNT, `TMR2_OFS_STATUS: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
			endcase
		end
	endfunction

	wire run      = ctrl_q[`TMR2_CTRL_RUN];
	wire cap_mode = ctrl_q[`TMR2_CTRL_CAPMODE];
	wire updown   = ctrl_q[`TMR2_CTRL_UPDOWN];
	wire ext_en   = ctrl_q[`TMR2_CTRL_EXTEN];
	wire rise_sel = ctrl_q[`TMR2_CTRL_RISE];
	wire pre_dis  = ctrl_q[`TMR2_CTRL_PREDIS];
	wire [1:0] irq_mask = ctrl_q[`TMR2_CTRL_MASK_LO+1:`TMR2_CTRL_MASK_LO];
	wire [1:0] mode     = mode_of(cap_mode, updown);

	// merge a 32-bit write into a narrower register under byte strobes
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			merge16 = old;
			if (be[0]) begin
				merge16[7:0] = wd[7:0];
			end
			if (be[1]) begin
				merge16[15:8] = wd[15:8];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// prescaler and pin edge detection
	// ----------------------------------------------------------------
	// with the prescaler off the counter steps once per twelve clocks; when
	// it is on, the divide-by-twelve is bypassed and the counter steps every clock
	wire pre_wrap = (pre_q == PRESCALE - 1);
	wire tick     = run && (pre_dis ? pre_wrap : 1'b1);
	wire pin_edge = edge_seen(rise_sel, ext_trigger_dir_pin, pin_q);

	// ----------------------------------------------------------------
	// counter events
	// ----------------------------------------------------------------
	wire count_up   = !(updown && !cap_mode && !ext_trigger_dir_pin);
	wire at_max     = (timer_count_value_q == `TMR2_ONES);
	wire overflow   = tick && count_up && at_max;
	wire underflow  = tick && !count_up && (timer_count_value_q == reload_capture_value_q);
	wire ext_reload = run && !cap_mode && !updown && ext_en && pin_edge;
	wire capture    = run && cap_mode && pin_edge;

	// reload flag: plain reload mode and capture overflow only; up/down silent
	wire ev_reload  = cap_mode ? overflow : (!updown && (overflow || ext_reload));
	wire ev_capture = capture;

	// ----------------------------------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------------------------------
	// readies drop while frozen, else a handshake would be lost
	assign s_axi_awready = clk_en && !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready  = clk_en && !w_full_q && !s_axi_bvalid;
	assign s_axi_arready = clk_en && !s_axi_rvalid;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire aw_have = aw_full_q || aw_take;
	wire w_have  = w_full_q || w_take;
	wire [3:0]  wr_addr = aw_full_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_full_q ? wdata_q : s_axi_wdata;
	wire [3:0]  wr_be   = w_full_q ? wstrb_q : s_axi_wstrb;
	wire wr_do = aw_have && w_have && !s_axi_bvalid;

	wire wr_ctrl   = wr_do && (wr_addr == `TMR2_OFS_CTRL);
	wire wr_reload = wr_do && (wr_addr == `TMR2_OFS_RELOAD);
	wire wr_count  = wr_do && (wr_addr == `TMR2_OFS_COUNT);
	wire wr_status = wr_do && (wr_addr == `TMR2_OFS_STATUS);
	wire [1:0] st_clr = (wr_status && wr_be[0]) ? wr_data[1:0] : 2'h0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			awaddr_q     <= 4'h0;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (clk_en) begin
			if (wr_do) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// unmapped offsets answer with a slave error
				s_axi_bresp  <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_full_q <= 1'b1;
					awaddr_q  <= s_axi_awaddr;
				end
				if (w_take) begin
					w_full_q <= 1'b1;
					wdata_q  <= s_axi_wdata;
					wstrb_q  <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (clk_en) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				case (s_axi_araddr)
				`TMR2_OFS_CTRL: begin
					s_axi_rdata <= {22'h000000, ctrl_q};
				end
				`TMR2_OFS_RELOAD: begin
					s_axi_rdata <= {16'h0000, reload_capture_value_q};
				end
				`TMR2_OFS_COUNT: begin
					s_axi_rdata <= {16'h0000, timer_count_value_q};
				end
				`TMR2_OFS_STATUS: begin
					s_axi_rdata <= {30'h00000000, status_q};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control and prescaler next values
	// ----------------------------------------------------------------
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl && wr_be[0]) begin
			ctrl_d[5:0] = wr_data[5:0];
		end
		if (wr_ctrl && wr_be[1]) begin
			ctrl_d[9:8] = wr_data[9:8];
		end
	end

	// divider restarts whenever the timer is stopped
	always @* begin
		if (!run || pre_wrap) begin
			pre_d = {`TMR2_PRE_W{1'b0}};
		end else begin
			pre_d = pre_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// counter next value
	// ----------------------------------------------------------------
	always @* begin
		timer_count_value_d = timer_count_value_q;
		case (mode)
		MODE_CAPTURE: begin
			if (overflow) begin
				timer_count_value_d = `TMR2_ZERO;
			end else if (tick) begin
				timer_count_value_d = timer_count_value_q + 16'h0001;
			end
		end
		MODE_UPDOWN: begin
			if (overflow) begin
				timer_count_value_d = reload_capture_value_q;
			end else if (underflow) begin
				timer_count_value_d = `TMR2_ONES;
			end else if (tick && count_up) begin
				timer_count_value_d = timer_count_value_q + 16'h0001;
			end else if (tick) begin
				timer_count_value_d = timer_count_value_q - 16'h0001;
			end
		end
		default: begin
			if (overflow || ext_reload) begin
				timer_count_value_d = reload_capture_value_q;
			end else if (tick) begin
				timer_count_value_d = timer_count_value_q + 16'h0001;
			end
		end
		endcase
		// a software write overrides counting in that cycle
		if (wr_count) begin
			timer_count_value_d = merge16(timer_count_value_q, wr_data, wr_be);
		end
	end

	// ----------------------------------------------------------------
	// reload/capture register and sticky flags
	// ----------------------------------------------------------------
	// software write loses to a same-cycle capture
	always @* begin
		reload_capture_value_d = reload_capture_value_q;
		if (capture) begin
			reload_capture_value_d = timer_count_value_q;
		end else if (wr_reload) begin
			reload_capture_value_d = merge16(reload_capture_value_q, wr_data, wr_be);
		end
	end

	// set wins over a same-cycle clear, so no event is lost
	always @* begin
		status_d = (status_q & ~st_clr) | {ev_capture, ev_reload};
	end

	// ----------------------------------------------------------------
	// register update
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q                 <= `TMR2_CTRL_RST;
			reload_capture_value_q <= `TMR2_CNT_RST;
			timer_count_value_q    <= `TMR2_CNT_RST;
			status_q               <= 2'h0;
			pre_q                  <= {`TMR2_PRE_W{1'b0}};
			pin_q                  <= 1'b0;
		end else if (clk_en) begin
			pin_q                  <= ext_trigger_dir_pin;
			ctrl_q                 <= ctrl_d;
			pre_q                  <= pre_d;
			reload_capture_value_q <= reload_capture_value_d;
			timer_count_value_q    <= timer_count_value_d;
			status_q               <= status_d;
		end
	end

	assign irq = |(status_q & irq_mask);

endmodule

`default_nettype wire
